//--- pkg/asd_pkg.sv
package asd_pkg;
    // ---------------------------------------------------------------
    // Widths
    // ---------------------------------------------------------------
    localparam int ADDR_W     = 32;
    localparam int PROG_W     = 26;
    localparam int PHYS_W     = 28;
    localparam int SPAN64_W   = 26;
    localparam int OFFS_W     = 16;

    // ---------------------------------------------------------------
    // Area map
    // ---------------------------------------------------------------
    localparam logic [PHYS_W-1:0] ROM_BASE_LOW   = 28'h0000000;
    localparam logic [PHYS_W-1:0] ROM_BASE_HIGH  = 28'h0100000;
    localparam logic [PHYS_W-1:0] ROM_SPAN_LAST  = 28'h00FFFFF;
    localparam logic [9:0]        RAM_PAGE_TOP   = 10'h3FF;
    localparam logic [OFFS_W-1:0] RAM_LAST_LOW   = 16'hEFFF;
    localparam logic [OFFS_W-1:0] RAM_BASE_4K    = 16'hE000;
    localparam logic [OFFS_W-1:0] RAM_BASE_12K   = 16'hC000;
    localparam logic [OFFS_W-1:0] RAM_BASE_28K   = 16'h8000;
    localparam logic [OFFS_W-1:0] RAM_BASE_60K   = 16'h0000;
    localparam logic [13:0]       IO_PAGE_TOP    = 14'h3FFF;
    localparam logic [1:0]        IMG_LOW        = 2'h0;
    localparam logic [1:0]        IMG_TOP        = 2'h3;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic              STRAP_RST      = 1'b0;
    localparam logic [2:0]        RAM_STRAP_RST  = 3'h0;
endpackage

//--- design/asd_window_hit.sv
module asd_window_hit #(
    parameter int W = 28
) (
    input  wire logic [W-1:0] addr,
    input  wire logic [W-1:0] first,
    input  wire logic [W-1:0] last,
    output wire logic         hit
);
    // Inclusive window compare
    assign hit = (addr >= first) && (addr <= last);
endmodule // asd_window_hit

//--- design/asd_decoder.sv
// Function
// RULE1: One 4 GB space holds memory and peripheral registers alike.
// RULE2: Fetch addresses are limited to a 64 MB program region.
// RULE3: Operand addresses are accepted over the full 4 GB range.
// RULE4: ROM, RAM and I/O lie in 64 MB or 256 MB span by strap.
// RULE5: Span strap low: bits 31..26 ignored, 64 images.
// RULE6: Span strap high: bits 31..28 ignored, 16 images.
// RULE7: Relocated ROM area is 1 MB starting at 0100000H.
// RULE8: 256 MB mode RAM below FFFEFFFH maps onto RAM below 3FFEFFFH.
// RULE9: Masters must avoid 3FFF000H..3FFFFFFH; behaviour not guaranteed.
// RULE10: ROM enable strap high enables the ROM area on fetch bus.
// RULE11: ROM base strap puts ROM at 0H or 100000H, 1 MB long.
// RULE12: RAM area ends at 3FFEFFFH or FFFEFFFH per span mode.
// RULE13: RAM size 4/12/28/60 KB from three straps, highest wins.
// RULE14: Peripheral I/O area occupies top of the physical span.
// RULE15: Each address gets exactly one of ROM, RAM, I/O, external.
module asd_decoder
    import asd_pkg::*;
(
    input  wire logic                      mclk,
    input  wire logic                      rst,
    input  wire logic                      data_span_select_pin,
    input  wire logic                      rom_area_enable_pin,
    input  wire logic                      rom_base_select_pin,
    input  wire logic                      ram_size_strap_high,
    input  wire logic                      ram_size_strap_mid,
    input  wire logic                      ram_size_strap_low,
    input  wire logic                      fetch_req,
    input  wire logic [asd_pkg::ADDR_W-1:0] fetch_addr,
    input  wire logic                      opnd_req,
    input  wire logic [asd_pkg::ADDR_W-1:0] opnd_addr,
    output logic                           fetch_valid,
    output logic [asd_pkg::PROG_W-1:0]     fetch_phys,
    output logic                           fetch_rom_sel,
    output logic                           fetch_ext_sel,
    output logic                           opnd_valid,
    output logic [asd_pkg::PHYS_W-1:0]     opnd_phys,
    output logic [asd_pkg::OFFS_W-1:0]     opnd_ram_offset,
    output logic                           opnd_rom_sel,
    output logic                           opnd_ram_sel,
    output logic                           opnd_io_sel,
    output logic                           opnd_ext_sel,
    output logic                           span_256_mode
);
    import asd_pkg::*;

    // ---------------------------------------------------------------
    // Strap sampling
    // ---------------------------------------------------------------
    logic       mode256;
    logic       rom_en;
    logic       rom_hi;
    logic [2:0] ram_strap;

    always_ff @(posedge mclk) begin
        if (rst) begin
            mode256   <= STRAP_RST;
            rom_en    <= STRAP_RST;
            rom_hi    <= STRAP_RST;
            ram_strap <= RAM_STRAP_RST;
        end else begin
            mode256   <= data_span_select_pin;
            rom_en    <= rom_area_enable_pin;
            rom_hi    <= rom_base_select_pin;
            ram_strap <= {ram_size_strap_high, ram_size_strap_mid, ram_size_strap_low};
        end
    end

    // ---------------------------------------------------------------
    // Area bounds
    // ---------------------------------------------------------------
    wire logic [PHYS_W-1:0] rom_first;
    wire logic [PHYS_W-1:0] rom_last;
    wire logic [OFFS_W-1:0] ram_base;

    assign rom_first = rom_hi ? ROM_BASE_HIGH : ROM_BASE_LOW; // RULE7 RULE11
    assign rom_last  = rom_first + ROM_SPAN_LAST;              // RULE11
    assign ram_base  = ram_strap[2] ? RAM_BASE_60K :           // RULE13
                       ram_strap[1] ? RAM_BASE_28K :
                       ram_strap[0] ? RAM_BASE_12K : RAM_BASE_4K;

    // ---------------------------------------------------------------
    // Fetch side decode
    // ---------------------------------------------------------------
    wire logic [PROG_W-1:0] f_phys;
    wire logic              f_rom_win;
    wire logic              f_rom;

    assign f_phys = fetch_addr[PROG_W-1:0]; // RULE2

    asd_window_hit #(.W(PROG_W)) u_fetch_rom (
        .addr  (f_phys),
        .first (rom_first[PROG_W-1:0]),
        .last  (rom_last[PROG_W-1:0]),
        .hit   (f_rom_win)
    );

    assign f_rom = rom_en && f_rom_win; // RULE10

    // ---------------------------------------------------------------
    // Operand side decode
    // ---------------------------------------------------------------
    wire logic [PHYS_W-1:0] o_phys;
    wire logic [1:0]        o_img;
    wire logic              o_top_img;
    wire logic              o_rom_win;
    wire logic              o_ram_win;
    wire logic              o_io_win;
    wire logic              o_rom;
    wire logic              o_ram;
    wire logic              o_io;
    wire logic              o_ext;
    wire logic [OFFS_W-1:0] o_ram_off;

    // RULE1 RULE3 RULE4 RULE5 RULE6
    assign o_phys    = mode256 ? opnd_addr[PHYS_W-1:0]
                               : {IMG_LOW, opnd_addr[SPAN64_W-1:0]};
    assign o_img     = o_phys[PHYS_W-1:SPAN64_W];
    // RULE8: both the top image and its low alias reach the same RAM
    assign o_top_img = !mode256 || (o_img == IMG_TOP) || (o_img == IMG_LOW);

    asd_window_hit #(.W(PHYS_W)) u_opnd_rom (
        .addr  (o_phys),
        .first (rom_first),
        .last  (rom_last),
        .hit   (o_rom_win)
    );

    asd_window_hit #(.W(OFFS_W)) u_opnd_ram (
        .addr  (o_phys[OFFS_W-1:0]),
        .first (ram_base),
        .last  (RAM_LAST_LOW),
        .hit   (o_ram_win)
    );

    assign o_rom     = o_rom_win;
    // RULE12 RULE8
    assign o_ram     = !o_rom && o_top_img && o_ram_win
                       && (o_phys[SPAN64_W-1:OFFS_W] == RAM_PAGE_TOP);
    // RULE14: I/O only at the top of the active span
    assign o_io      = !o_rom && (o_phys[SPAN64_W-1:12] == IO_PAGE_TOP)
                       && (!mode256 || (o_img == IMG_TOP));
    assign o_ext     = !o_rom && !o_ram && !o_io; // RULE15
    assign o_ram_off = o_phys[OFFS_W-1:0] - ram_base; // RULE8

    // ---------------------------------------------------------------
    // Output registers
    // ---------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            fetch_valid     <= 1'b0;
            fetch_phys      <= '0;
            fetch_rom_sel   <= 1'b0;
            fetch_ext_sel   <= 1'b0;
        end else begin
            fetch_valid     <= fetch_req;
            fetch_phys      <= f_phys;
            fetch_rom_sel   <= fetch_req && f_rom;  // RULE10
            fetch_ext_sel   <= fetch_req && !f_rom; // RULE15
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            opnd_valid      <= 1'b0;
            opnd_phys       <= '0;
            opnd_ram_offset <= '0;
            opnd_rom_sel    <= 1'b0;
            opnd_ram_sel    <= 1'b0;
            opnd_io_sel     <= 1'b0;
            opnd_ext_sel    <= 1'b0;
        end else begin
            opnd_valid      <= opnd_req;
            opnd_phys       <= o_phys;
            opnd_ram_offset <= o_ram_off;
            opnd_rom_sel    <= opnd_req && o_rom;
            opnd_ram_sel    <= opnd_req && o_ram;
            opnd_io_sel     <= opnd_req && o_io;
            opnd_ext_sel    <= opnd_req && o_ext;
        end
    end

    assign span_256_mode = mode256; // RULE4

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    chk_opnd_one_select: assert property (@(posedge mclk) disable iff (rst) // RULE15
        opnd_valid |-> $onehot({opnd_rom_sel, opnd_ram_sel, opnd_io_sel, opnd_ext_sel}))
        else $error("operand select not one-hot");

    chk_fetch_one_select: assert property (@(posedge mclk) disable iff (rst) // RULE15
        fetch_valid == (fetch_rom_sel || fetch_ext_sel) && !(fetch_rom_sel && fetch_ext_sel))
        else $error("fetch select not exclusive");

    chk_span64_alias: assert property (@(posedge mclk) disable iff (rst) // RULE5
        (opnd_req && !mode256) |=> opnd_phys == {2'h0, $past(opnd_addr[25:0])})
        else $error("64 MB alias wrong");

    chk_span256_alias: assert property (@(posedge mclk) disable iff (rst) // RULE6
        (opnd_req && mode256) |=> opnd_phys == $past(opnd_addr[27:0]))
        else $error("256 MB alias wrong");

    chk_fetch_prog_limit: assert property (@(posedge mclk) disable iff (rst) // RULE2
        fetch_req |=> fetch_phys == $past(fetch_addr[25:0]))
        else $error("fetch address not cut to 64 MB");

    chk_rom_base_place: assert property (@(posedge mclk) disable iff (rst) // RULE11
        (fetch_req && rom_en) |=> fetch_rom_sel ==
            ($past(fetch_addr[25:20]) == ($past(rom_hi) ? 6'h01 : 6'h00)))
        else $error("ROM window misplaced");

    chk_rom_enable_gate: assert property (@(posedge mclk) disable iff (rst) // RULE10
        !rom_en |=> !fetch_rom_sel)
        else $error("ROM selected while disabled");

    chk_ram_size_base: assert property (@(posedge mclk) disable iff (rst) // RULE13
        (opnd_req && ram_strap[2] && opnd_addr[25:12] == 14'h3FF0
            && (!mode256 || opnd_addr[27:26] == 2'h0 || opnd_addr[27:26] == 2'h3))
        |=> opnd_ram_sel)
        else $error("60 KB RAM bottom not selected");

    chk_ram_offset_link: assert property (@(posedge mclk) disable iff (rst) // RULE8
        opnd_ram_sel |-> opnd_ram_offset == opnd_phys[15:0]
            - ($past(ram_strap[2]) ? RAM_BASE_60K : $past(ram_strap[1]) ? RAM_BASE_28K
            : $past(ram_strap[0]) ? RAM_BASE_12K : RAM_BASE_4K))
        else $error("RAM offset not linked");

    chk_io_top_page: assert property (@(posedge mclk) disable iff (rst) // RULE14
        opnd_io_sel |-> opnd_phys[25:12] == 14'h3FFF)
        else $error("I/O select outside top page");
endmodule // asd_decoder

//--- sim/asd_cpu_model.sv
module asd_cpu_model (
    input  wire logic        mclk,
    input  wire logic        span,
    input  wire logic        cmd_f,
    input  wire logic [31:0] cmd_fa,
    input  wire logic        cmd_o,
    input  wire logic [31:0] cmd_oa,
    output logic             fetch_req,
    output logic [31:0]      fetch_addr,
    output logic             opnd_req,
    output logic [31:0]      opnd_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    wire logic barred = span && (cmd_oa[27:12] == 16'h3FFF);
    initial begin
        fetch_req = 1'b0;
        fetch_addr = 32'h0;
        opnd_req = 1'b0;
        opnd_addr = 32'h0;
    end
    // Idle address lines toggle rather than hold
    always @(posedge mclk) begin
        fetch_req <= cmd_f;
        fetch_addr <= cmd_f ? cmd_fa : ~fetch_addr;
        opnd_req <= cmd_o && !barred;
        opnd_addr <= (cmd_o && !barred) ? cmd_oa : ~opnd_addr;
    end
endmodule // asd_cpu_model

//--- sim/address_space_decoder_tb.sv
module address_space_decoder_tb;
    import asd_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0, rst = 1'b1, span = 1'b0, re = 1'b0, rbs = 1'b0;
    logic rhi = 1'b0, rmid = 1'b0, rlo = 1'b0, cmd_f = 1'b0, cmd_o = 1'b0;
    logic [31:0] cmd_fa = 32'h0, cmd_oa = 32'h0, fa, oa;
    logic fr, orq, fv, frs, fes, ov, ors, ras, ios, oes, s256;
    logic [25:0] fph;
    logic [27:0] oph;
    logic [15:0] off;
    logic [27:0] fq[$];
    logic [48:0] oq[$];
    logic [27:0] fe;
    logic [48:0] oe;
    int errors = 0, tests_run = 0;
    logic [31:0] dir[13] = '{32'h0, 32'h000FFFFF, 32'h00100000, 32'h001FFFFF, 32'hFC3FE010,
        32'h03FFDFFF, 32'h03FFC000, 32'h03FF8000, 32'h03FFEFFF, 32'h03FFF000, 32'h0FFFEFFF,
        32'hFFFFFFFF, 32'h03FF0000};
    initial forever #50 mclk = ~mclk;
    asd_cpu_model cpu (.mclk(mclk), .span(span), .cmd_f(cmd_f), .cmd_fa(cmd_fa), .cmd_o(cmd_o),
        .cmd_oa(cmd_oa), .fetch_req(fr), .fetch_addr(fa), .opnd_req(orq), .opnd_addr(oa));
    asd_decoder dut (.mclk(mclk), .rst(rst), .data_span_select_pin(span),
        .rom_area_enable_pin(re), .rom_base_select_pin(rbs), .ram_size_strap_high(rhi),
        .ram_size_strap_mid(rmid), .ram_size_strap_low(rlo), .fetch_req(fr), .fetch_addr(fa),
        .opnd_req(orq), .opnd_addr(oa), .fetch_valid(fv), .fetch_phys(fph),
        .fetch_rom_sel(frs), .fetch_ext_sel(fes), .opnd_valid(ov), .opnd_phys(oph),
        .opnd_ram_offset(off), .opnd_rom_sel(ors), .opnd_ram_sel(ras), .opnd_io_sel(ios),
        .opnd_ext_sel(oes), .span_256_mode(s256));
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            errors++;
        end
    endtask
    task automatic print_verdict;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    function automatic logic [48:0] op_exp(input logic [31:0] a);
        logic [27:0] p;
        logic [15:0] rb;
        logic rom, ram, io;
        p = span ? a[27:0] : {2'h0, a[25:0]};
        rb = rhi ? 16'h0000 : rmid ? 16'h8000 : rlo ? 16'hC000 : 16'hE000;
        rom = p[27:20] == {7'h00, rbs};
        ram = p[25:16] == 10'h3FF && (!span || p[27:26] == 2'h0 || p[27:26] == 2'h3)
            && p[15:0] >= rb && p[15:0] <= 16'hEFFF;
        io = span ? p[27:12] == 16'hFFFF : p[25:12] == 14'h3FFF;
        return {span, rom, !rom && ram, !rom && !ram && io, !rom && !ram && !io, p[15:0] - rb, p};
    endfunction
    task automatic send(input logic f, input logic [31:0] a, input logic o, input logic [31:0] b);
        @(posedge mclk);
        cmd_f <= f;
        cmd_fa <= a;
        cmd_o <= o;
        cmd_oa <= b;
        if (f) fq.push_back({re && a[25:20] == {5'h00, rbs}, !(re && a[25:20] == {5'h00, rbs}),
            a[25:0]});
        if (o && !(span && b[27:12] == 16'h3FFF)) oq.push_back(op_exp(b));
    endtask
    task automatic drain;
        send(1'b0, 32'h0, 1'b0, 32'h0);
        for (int k = 0; k < 10 && (fq.size() + oq.size()) > 0; k++) @(posedge mclk);
        check("queues drained", 0, fq.size() + oq.size());
        if (fq.size() + oq.size() > 0) print_verdict;
    endtask
    always @(negedge mclk) if (!rst) begin
        if (fv === 1'b1 && fq.size() > 0) begin
            fe = fq.pop_front();
            check("fetch", fe, {frs, fes, fph});
        end else if (fv !== 1'b0) check("fetch extra", 0, 1);
        else check("fetch idle", 0, {frs, fes});
        if (ov === 1'b1 && oq.size() > 0) begin
            oe = oq.pop_front();
            check("opnd sel", oe[48:44], {s256, ors, ras, ios, oes});
            check("opnd_phys", oe[27:0], oph);
            if (oe[46]) check("opnd_ram_offset", oe[43:28], off);
        end else if (ov !== 1'b0) check("opnd extra", 0, 1);
        else check("opnd idle", 0, {ors, ras, ios, oes});
    end
    initial begin
        void'($urandom(83));
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        for (int c = 0; c < 32; c++) begin
            @(posedge mclk);
            {span, re, rbs} <= 3'(c);
            {rhi, rmid, rlo} <= {c[4] & c[3], c[4], c[3] | c[4]};
            repeat (2) @(posedge mclk);
            foreach (dir[i]) send(1'b1, dir[i], 1'b1, dir[i]);
            repeat (8) send(1'($urandom), $urandom, 1'($urandom), $urandom);
            drain();
        end
        send(1'b1, 32'h0, 1'b1, 32'h03FFE000);
        send(1'b0, 32'h0, 1'b0, 32'h0);
        rst <= 1'b1;
        fq.delete();
        oq.delete();
        repeat (2) @(posedge mclk);
        #1 check("reset outputs", 0, {fv, frs, fes, ov, ors, ras, ios, oes, s256});
        @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        send(1'b1, 32'h00000040, 1'b1, 32'h03FFF010);
        drain();
        print_verdict();
    end
endmodule // address_space_decoder_tb
